// file: i2cw_consts.svh
`ifndef I2CW_CONSTS_SVH
`define I2CW_CONSTS_SVH

// Core clock period and bus bit period, in ns
`define I2CW_CLK_NS        100
`define I2CW_SCL_PERIOD_NS 10000
// Quarter bit time in core cycles, rounded down
`define I2CW_QTR_CYC       ((`I2CW_SCL_PERIOD_NS) / (4 * `I2CW_CLK_NS))

// Control word bit positions
`define I2CW_CTL_EN        7
`define I2CW_CTL_START     6
`define I2CW_CTL_STOP      5
`define I2CW_CTL_TXI       3
`define I2CW_CTL_FLUSH     1

// Reset values
`define I2CW_CTL_RST       8'h00
`define I2CW_DATA_RST      8'h00

`endif

// file: i2cw_master_tail.sv
`timescale 1ns/1ns
`include "i2cw_consts.svh"

module i2cw_master_tail
  import i2cw_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       SRST,
  input  wire logic       CTL_WR,
  input  wire logic [7:0] CTL_WDATA,
  input  wire logic       DATA_WR,
  input  wire logic [7:0] DATA_WDATA,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic      [7:0] CTL_RDATA,
  output logic            ACK_FLAG,
  output logic            NAK_IRQ_FLAG,
  output logic            TX_DATA_EMPTY_FLAG,
  output logic            TX_IRQ,
  output logic            DMA_TX_REQ,
  output logic            SCL_O,
  output logic            SCL_OE,
  output logic            SDA_O,
  output logic            SDA_OE
);

  localparam logic [7:0] QTR_LAST = 8'(`I2CW_QTR_CYC - 1);

  i2cw_state_e state;
  i2cw_state_e next_state;
  i2cw_phase_t phase;
  i2cw_byte_t  data_reg;
  i2cw_byte_t  shifter;
  logic [7:0]  qcnt;
  logic [2:0]  bitcnt;
  logic        controller_enable;
  logic        start_req;
  logic        stop_req;
  logic        tx_empty_irq_enable;
  logic        scl_m;
  logic        scl_s;
  logic        sda_m;
  logic        sda_s;
  logic        next_scl_low;
  logic        next_sda_low;
  logic        tick;
  logic        last_tick;
  logic        running;
  logic        load_byte;
  logic        first_bit_done;
  logic        start_sent;
  logic        stop_sent;
  logic        ack_seen;
  logic        ack_sample;

  wire ctl_set_start = CTL_WR & CTL_WDATA[`I2CW_CTL_START];
  wire ctl_set_stop  = CTL_WR & CTL_WDATA[`I2CW_CTL_STOP];
  wire ctl_flush     = CTL_WR & CTL_WDATA[`I2CW_CTL_FLUSH];

  // Two-stage synchronisers for the bus lines
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      sda_m <= SDA_I;
      sda_s <= sda_m;
    end
  end

  // Quarter-bit timer, held while a released SCL is still low
  assign running   = (state != I2CW_IDLE) && (state != I2CW_WAIT);
  assign tick      = running && (qcnt == QTR_LAST) && (SCL_OE || scl_s);
  assign last_tick = tick && (phase == 2'h3);

  always_ff @(posedge CORE_CLK) begin
    if (SRST || !running) begin
      qcnt  <= 8'h00;
      phase <= 2'h0;
    end else if (qcnt != QTR_LAST) begin
      qcnt <= qcnt + 8'h01;
    end else if (tick) begin
      qcnt  <= 8'h00;
      phase <= phase + 2'h1;
    end
  end

  assign load_byte      = (state == I2CW_START && last_tick) ||
                          (next_state == I2CW_BITS && state == I2CW_WAIT);
  assign first_bit_done = state == I2CW_BITS && last_tick &&
                          bitcnt == 3'h0;
  assign start_sent     = state == I2CW_START && last_tick;
  assign stop_sent      = state == I2CW_STOP && last_tick;
  assign ack_sample     = state == I2CW_ACK && tick && phase == 2'h1;

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      I2CW_IDLE: begin
        if (start_req && !TX_DATA_EMPTY_FLAG)
          next_state = I2CW_START;
      end
      I2CW_START: begin
        if (last_tick)
          next_state = I2CW_BITS;
      end
      I2CW_BITS: begin
        if (last_tick && bitcnt == 3'h7)
          next_state = I2CW_ACK;
      end
      I2CW_ACK: begin
        if (last_tick)
          next_state = I2CW_WAIT;
      end
      I2CW_WAIT: begin
        if (stop_req)
          next_state = I2CW_STOP;
        else if (start_req && !TX_DATA_EMPTY_FLAG && !NAK_IRQ_FLAG)
          next_state = I2CW_START;
        else if (!TX_DATA_EMPTY_FLAG && !NAK_IRQ_FLAG)
          next_state = I2CW_BITS;
      end
      I2CW_STOP: begin
        if (last_tick)
          next_state = I2CW_IDLE;
      end
      default: next_state = I2CW_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST || !controller_enable)
      state <= I2CW_IDLE;
    else
      state <= next_state;
  end

  // Shift register and bit counter, MSB first
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      shifter <= `I2CW_DATA_RST;
      bitcnt  <= 3'h0;
    end else if (load_byte) begin
      shifter <= data_reg;
      bitcnt  <= 3'h0;
    end else if (state == I2CW_BITS && last_tick) begin
      shifter <= {shifter[6:0], 1'b0};
      bitcnt  <= bitcnt + 3'h1;
    end
  end

  // Line levels per state and quarter
  always_comb begin
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    case (state)
      I2CW_START: begin
        next_scl_low = (phase == 2'h0) || (phase == 2'h3);
        next_sda_low = phase[1];
      end
      I2CW_BITS: begin
        next_scl_low = (phase == 2'h0) || (phase == 2'h3);
        next_sda_low = !shifter[7];
      end
      I2CW_ACK: begin
        next_scl_low = (phase == 2'h0) || (phase == 2'h3);
      end
      I2CW_WAIT: begin
        next_scl_low = 1'b1;
      end
      I2CW_STOP: begin
        next_scl_low = (phase == 2'h0);
        next_sda_low = !phase[1];
      end
      default: begin
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      SCL_OE <= 1'b0;
      SDA_OE <= 1'b0;
      SCL_O  <= 1'b0;
      SDA_O  <= 1'b0;
    end else begin
      SCL_OE <= next_scl_low;
      SDA_OE <= next_sda_low;
      SCL_O  <= 1'b0;
      SDA_O  <= 1'b0;
    end
  end

  // Control bits; a set from software wins over a hardware clear
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      controller_enable   <= 1'(`I2CW_CTL_RST >> `I2CW_CTL_EN);
      tx_empty_irq_enable <= 1'b0;
      start_req           <= 1'b0;
      stop_req            <= 1'b0;
    end else begin
      if (CTL_WR) begin
        controller_enable   <= CTL_WDATA[`I2CW_CTL_EN];
        tx_empty_irq_enable <= CTL_WDATA[`I2CW_CTL_TXI];
      end
      if (CTL_WR && !CTL_WDATA[`I2CW_CTL_EN]) begin
        start_req <= 1'b0;
        stop_req  <= 1'b0;
      end else begin
        start_req <= ctl_set_start || (start_req && !start_sent);
        stop_req  <= ctl_set_stop || (stop_req && !stop_sent);
      end
    end
  end

  // Data register and its empty flag
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      data_reg           <= `I2CW_DATA_RST;
      TX_DATA_EMPTY_FLAG <= 1'b1;
    end else if (DATA_WR) begin
      data_reg           <= DATA_WDATA;
      TX_DATA_EMPTY_FLAG <= 1'b0;
    end else if (ctl_flush) begin
      data_reg           <= `I2CW_DATA_RST;
      TX_DATA_EMPTY_FLAG <= 1'b1;
    end else if (first_bit_done) begin
      TX_DATA_EMPTY_FLAG <= 1'b1;
    end
  end

  // Acknowledge sample and status flags
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ack_seen <= 1'b0;
    end else if (ack_sample) begin
      ack_seen <= !sda_s;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ACK_FLAG     <= 1'b0;
      NAK_IRQ_FLAG <= 1'b0;
    end else begin
      if (state == I2CW_ACK && last_tick) begin
        ACK_FLAG <= ack_seen;
      end
      if (state == I2CW_ACK && last_tick && !ack_seen &&
          !stop_req && !start_req)
        NAK_IRQ_FLAG <= 1'b1;
      else if (stop_sent || !controller_enable)
        NAK_IRQ_FLAG <= 1'b0;
    end
  end

  // Interrupt, DMA request and readback
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      TX_IRQ     <= 1'b0;
      DMA_TX_REQ <= 1'b0;
      CTL_RDATA  <= `I2CW_CTL_RST;
    end else begin
      TX_IRQ     <= tx_empty_irq_enable && TX_DATA_EMPTY_FLAG;
      DMA_TX_REQ <= tx_empty_irq_enable && TX_DATA_EMPTY_FLAG;
      CTL_RDATA  <= {controller_enable, start_req, stop_req, 1'b0,
                     tx_empty_irq_enable, 3'b000};
    end
  end

endmodule

// file: i2cw_pkg.sv
package i2cw_pkg;
  typedef enum logic [5:0] {
    I2CW_IDLE  = 6'b000001,
    I2CW_START = 6'b000010,
    I2CW_BITS  = 6'b000100,
    I2CW_ACK   = 6'b001000,
    I2CW_WAIT  = 6'b010000,
    I2CW_STOP  = 6'b100000
  } i2cw_state_e;
  typedef logic [7:0] i2cw_byte_t;
  typedef logic [1:0] i2cw_phase_t;
endpackage

// file: i2cw_slave_model.sv
`timescale 1ns/1ns
module i2cw_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  output logic            sda_oe,
  output logic      [7:0] rx_byte,
  output int              n_acks
);
  int         n = 0;
  logic [7:0] sh = 8'h00;
  initial sda_oe = 1'b0;
  initial rx_byte = 8'h00;
  initial n_acks = 0;
  // Start or restart restarts the bit count
  always @(negedge sda) if (scl === 1'b1) n = 0;
  // Sample on SCL rise, MSB first
  always @(posedge scl) sh = {sh[6:0], sda};
  // Pull SDA low through the ninth clock
  always @(negedge scl) begin
    n = n + 1;
    if (n % 9 == 1 && n > 1) n_acks = n_acks + 1;
    if (n % 9 == 0) rx_byte = sh;
    sda_oe = ack_en && (n % 9 == 0);
  end
endmodule

// file: i2cw_tail_sva.sv
`timescale 1ns/1ns
module i2cw_tail_sva (
  input wire logic       CORE_CLK,
  input wire logic       SRST,
  input wire logic [7:0] CTL_RDATA,
  input wire logic       ACK_FLAG,
  input wire logic       NAK_IRQ_FLAG,
  input wire logic       TX_DATA_EMPTY_FLAG,
  input wire logic       TX_IRQ,
  input wire logic       DMA_TX_REQ,
  input wire logic       SCL_OE,
  input wire logic       SDA_OE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // Bus edges made with SCL released on both sides
  sequence s_stop;
    $fell(SDA_OE) && !SCL_OE && !$past(SCL_OE);
  endsequence
  sequence s_start;
    $rose(SDA_OE) && !SCL_OE && !$past(SCL_OE);
  endsequence
  // Properties
  property p_irq;
    TX_IRQ == (CTL_RDATA[3] && $past(TX_DATA_EMPTY_FLAG));
  endproperty
  property p_dma;
    DMA_TX_REQ == TX_IRQ;
  endproperty
  property p_flush;
    CTL_RDATA[1] == 1'b0;
  endproperty
  property p_excl;
    !(ACK_FLAG && NAK_IRQ_FLAG);
  endproperty
  property p_nak;
    $rose(NAK_IRQ_FLAG) |-> CTL_RDATA[6:5] == 2'b00 && $past(SCL_OE);
  endproperty
  property p_ack;
    $rose(ACK_FLAG) |-> $past(SCL_OE) && !NAK_IRQ_FLAG;
  endproperty
  property p_stop_clr;
    s_stop |-> ##[1:60] (CTL_RDATA[5] == 1'b0 && !NAK_IRQ_FLAG);
  endproperty
  property p_stop_idle;
    s_stop |=> (!SCL_OE && !SDA_OE) [*8];
  endproperty
  property p_start;
    s_start |-> ##[1:30] SCL_OE ##[1:40] !CTL_RDATA[6];
  endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  a_dma: assert property (p_dma) else $error("dma wrong");
  a_flush: assert property (p_flush) else $error("flush read");
  a_excl: assert property (p_excl) else $error("ack and nak");
  a_nak: assert property (p_nak) else $error("nak early");
  a_ack: assert property (p_ack) else $error("ack timing");
  a_stop_clr: assert property (p_stop_clr) else $error("stop");
  a_stop_idle: assert property (p_stop_idle) else $error("idle");
  a_start: assert property (p_start) else $error("start");
  // Main scenarios
  c_nak: cover property ($rose(NAK_IRQ_FLAG));
  c_stop: cover property (s_stop);
  c_irq: cover property ($rose(TX_IRQ));
endmodule
bind i2cw_master_tail i2cw_tail_sva u_i2cw_tail_sva (.CORE_CLK, .SRST,
  .CTL_RDATA, .ACK_FLAG, .NAK_IRQ_FLAG, .TX_DATA_EMPTY_FLAG, .TX_IRQ,
  .DMA_TX_REQ, .SCL_OE, .SDA_OE);

// file: testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 3000) begin cyc(1); \
  k++; end if (!(c)) begin fail_count++; \
  $display("[ERR] t=%0t wait too long", $time); print_verdict; end end
module testbench;
  import i2cw_pkg::*;
  typedef struct packed {i2cw_byte_t d; logic ack; logic stp;} i2cw_row_s;
  logic       CORE_CLK = 0, SRST = 1, CTL_WR = 0, DATA_WR = 0, ack_en = 0;
  logic [7:0] CTL_WDATA = 8'h00, DATA_WDATA = 8'h00, CTL_RDATA, rx_byte;
  logic       ACK_FLAG, NAK_IRQ_FLAG, TX_DATA_EMPTY_FLAG, TX_IRQ;
  logic       DMA_TX_REQ, SCL_O, SCL_OE, SDA_O, SDA_OE, slv_oe;
  int         fail_count = 0, n_checks = 0, n_acks, k, i;
  i2cw_row_s  rows [4] = '{'{8'hA5, 1'b1, 1'b1}, '{8'h3C, 1'b0, 1'b1},
                           '{8'h5A, 1'b0, 1'b0}, '{8'h81, 1'b1, 1'b0}};
  // Pull-ups on both bus wires
  wire scl = (SCL_OE === 1'b1) ? 1'b0 : 1'b1;
  wire sda = (SDA_OE === 1'b1 || slv_oe === 1'b1) ? 1'b0 : 1'b1;
  i2cw_master_tail u_i2cw_master_tail (.CORE_CLK, .SRST, .CTL_WR,
    .CTL_WDATA, .DATA_WR, .DATA_WDATA, .SCL_I(scl), .SDA_I(sda),
    .CTL_RDATA, .ACK_FLAG, .NAK_IRQ_FLAG, .TX_DATA_EMPTY_FLAG, .TX_IRQ,
    .DMA_TX_REQ, .SCL_O, .SCL_OE, .SDA_O, .SDA_OE);
  i2cw_slave_model u_i2cw_slave_model (.scl, .sda, .ack_en,
    .sda_oe(slv_oe), .rx_byte, .n_acks);
  always #50 CORE_CLK = ~CORE_CLK;
  // Wait cycles, then settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  // One-cycle write strobes
  task automatic ctl(input logic [7:0] v);
    cyc(1);
    CTL_WR = 1'b1;
    CTL_WDATA = v;
    cyc(1);
    CTL_WR = 1'b0;
  endtask
  task automatic dat(input logic [7:0] v);
    cyc(1);
    DATA_WR = 1'b1;
    DATA_WDATA = v;
    cyc(1);
    DATA_WR = 1'b0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One-byte write transfers, then the awkward cases
  initial begin
    cyc(8);
    SRST = 1'b0;
    for (i = 0; i < 4; i++) begin
      ack_en = rows[i].ack;
      dat(rows[i].d);
      ctl(8'hC8);
      `WAITC(TX_DATA_EMPTY_FLAG === 1'b1)
      cyc(2);
      `CHK(TX_IRQ, 1'b1)
      if (rows[i].stp) ctl(8'hA0);
      `WAITC(n_acks == i + 1)
      cyc(40);
      `CHK(rx_byte, rows[i].d)
      `CHK(ACK_FLAG, rows[i].ack)
      `CHK(NAK_IRQ_FLAG, !rows[i].ack && !rows[i].stp)
      if (!rows[i].stp) ctl(8'hA2);
      cyc(2);
      `CHK(CTL_RDATA[5], 1'b1)
      `WAITC(CTL_RDATA[5] === 1'b0)
      cyc(2);
      `CHK({NAK_IRQ_FLAG, scl, sda}, 3'b011)
      $display("row %0d done", i);
    end
    // Restart after a refused last byte, then a stop
    ack_en = 1'b0;
    dat(8'h96);
    ctl(8'hC8);
    `WAITC(TX_DATA_EMPTY_FLAG === 1'b1)
    dat(8'h69);
    ctl(8'hC0);
    `WAITC(n_acks == 5)
    cyc(40);
    `CHK(rx_byte, 8'h96)
    `CHK({ACK_FLAG, NAK_IRQ_FLAG, CTL_RDATA[6]}, 3'b001)
    ack_en = 1'b1;
    `WAITC(CTL_RDATA[6] === 1'b0)
    `CHK(TX_DATA_EMPTY_FLAG, 1'b0)
    `WAITC(TX_DATA_EMPTY_FLAG === 1'b1)
    ctl(8'hA0);
    `WAITC(n_acks == 6)
    cyc(40);
    `CHK({rx_byte, ACK_FLAG}, 9'h0D3)
    `WAITC(CTL_RDATA[5] === 1'b0)
    $display("restart done");
    ctl(8'hE0);
    ctl(8'h80);
    cyc(3);
    `CHK(CTL_RDATA, 8'hE0)
    ctl(8'h00);
    cyc(3);
    `CHK(CTL_RDATA, 8'h00)
    ctl(8'h88);
    cyc(1);
    `CHK({TX_IRQ, DMA_TX_REQ}, 2'b11)
    dat(8'h55);
    cyc(3);
    `CHK({TX_DATA_EMPTY_FLAG, TX_IRQ}, 2'b00)
    ctl(8'h8A);
    cyc(3);
    `CHK({TX_DATA_EMPTY_FLAG, TX_IRQ, CTL_RDATA}, 10'h388)
    $display("flush done");
    SRST = 1'b1;
    cyc(2);
    `CHK({CTL_RDATA, ACK_FLAG, NAK_IRQ_FLAG, TX_DATA_EMPTY_FLAG}, 11'h001)
    `CHK({SCL_OE, SDA_OE, TX_IRQ}, 3'b000)
    $display("reset done");
    print_verdict;
  end
endmodule
